// ===== rtl/sacm_top.sv
// servo alarm and warning manager with coded alarm outputs
// ----------------------------------------
// What this block does
// - report each fault as alarm or warning
// - code output only when digit is one
// - code bits on outputs a, b, c
// - warnings never put a code out
// - normal functions pass while no alarm
// - absolute encoder 1/2: 110, power only
// - encoder type mismatch: 000, power only
// - control circuit group shows code 011
// - limit warning releases by itself
// - position table range: power, set, clear input or servo-on
// - position table errors: power, set, clear
// - overload warning 4 releases by itself
// - absolute encoder error 3 releases itself
// - servo-on rising edge clears range alarm
// - fault flag while any alarm active
// - caution flag while any warning active
// ----------------------------------------
`timescale 1ns/10ps
`include "sacm_cfg.svh"
module sacm_top #(
  parameter int NUM_ALARMS = `SACM_NUM_ALARMS,
  parameter int NUM_WARNS = `SACM_NUM_WARNS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NUM_ALARMS-1:0] alarm_cause,
  input wire logic [NUM_WARNS-1:0] warning_cause,
  input wire logic set_button_pin,
  input wire logic alarm_clear_input,
  input wire logic servo_on_pin,
  input wire logic normal_do_a,
  input wire logic normal_do_b,
  input wire logic normal_do_c,
  output logic coded_output_bit_a,
  output logic coded_output_bit_b,
  output logic coded_output_bit_c,
  output logic fault_flag_output,
  output logic caution_flag_output,
  output logic [7:0] display_code,
  output logic display_is_alarm,
  output logic irq
);

  // ----------------------------------------
  // alarm table and helpers
  // ----------------------------------------

  // display number, code a/b/c, clear by set button, clear input, servo-on
  function automatic sacm_pkg::sacm_alarm_info_type alarm_info(input logic [5:0] idx);
    sacm_pkg::sacm_alarm_info_type r;
    r = '0;
    case (idx)
      6'd0: r = {8'h01, 3'b010, 3'b000};
      6'd1: r = {8'h02, 3'b001, 3'b110};
      6'd2: r = {8'h03, 3'b011, 3'b000};
      6'd3: r = {8'h04, 3'b010, 3'b110};
      6'd4: r = {8'h05, 3'b100, 3'b110};
      6'd5: r = {8'h06, 3'b101, 3'b110};
      6'd6: r = {8'h07, 3'b101, 3'b110};
      6'd7: r = {8'h08, 3'b101, 3'b110};
      6'd8: r = {8'h09, 3'b000, 3'b110};
      6'd9: r = {8'h0a, 3'b000, 3'b110};
      6'd10: r = {8'h0b, 3'b110, 3'b000};
      6'd11: r = {8'h0d, 3'b110, 3'b000};
      6'd12: r = {8'h0e, 3'b000, 3'b000};
      6'd13: r = {8'h0f, 3'b000, 3'b000};
      6'd14: r = {8'h10, 3'b000, 3'b000};
      6'd15: r = {8'h11, 3'b111, 3'b000};
      6'd16: r = {8'h20, 3'b111, 3'b000};
      6'd17: r = {8'h21, 3'b111, 3'b000};
      6'd18: r = {8'h22, 3'b110, 3'b000};
      6'd19: r = {8'h24, 3'b000, 3'b000};
      6'd20: r = {8'h26, 3'b110, 3'b000};
      6'd21: r = {8'h27, 3'b110, 3'b000};
      6'd22: r = {8'h28, 3'b110, 3'b000};
      6'd23: r = {8'h29, 3'b110, 3'b000};
      6'd24: r = {8'h2a, 3'b110, 3'b000};
      6'd25: r = {8'h2b, 3'b110, 3'b000};
      6'd26: r = {8'h2e, 3'b011, 3'b000};
      6'd27: r = {8'h2f, 3'b011, 3'b000};
      6'd28: r = {8'h30, 3'b011, 3'b110};
      6'd29: r = {8'h31, 3'b011, 3'b000};
      6'd30: r = {8'h32, 3'b011, 3'b000};
      6'd31: r = {8'h33, 3'b011, 3'b000};
      6'd32: r = {8'h34, 3'b000, 3'b000};
      6'd33: r = {8'h61, 3'b000, 3'b111};
      6'd34: r = {8'h62, 3'b000, 3'b110};
      6'd35: r = {8'h63, 3'b000, 3'b110};
      6'd36: r = {8'h64, 3'b000, 3'b110};
      default: r = '0;
    endcase
    return r;
  endfunction

  // warning display numbers
  function automatic logic [7:0] warn_disp(input logic [3:0] idx);
    logic [7:0] d;
    d = 8'h00;
    case (idx)
      4'd0: d = 8'h12;
      4'd1: d = 8'h13;
      4'd2: d = 8'h14;
      4'd3: d = 8'h15;
      4'd4: d = 8'h16;
      4'd5: d = 8'h17;
      4'd6: d = 8'h18;
      4'd7: d = 8'h19;
      4'd8: d = 8'h1a;
      4'd9: d = 8'h1b;
      4'd10: d = 8'h1c;
      4'd11: d = 8'h2c;
      4'd12: d = 8'h2d;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  // lowest set bit of the alarm vector
  function automatic logic [5:0] first_alarm(input logic [NUM_ALARMS-1:0] v);
    logic [5:0] f;
    f = 6'd0;
    for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
      if (v[i]) begin
        f = 6'(i);
      end
    end
    return f;
  endfunction

  // lowest set bit of the warning vector
  function automatic logic [3:0] first_warn(input logic [NUM_WARNS-1:0] v);
    logic [3:0] f;
    f = 4'd0;
    for (int i = NUM_WARNS - 1; i >= 0; i--) begin
      if (v[i]) begin
        f = 4'(i);
      end
    end
    return f;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [2:0] pins_sync;
  logic set_s;
  logic res_s;
  logic son_s;
  logic set_prev_q;
  logic res_prev_q;
  logic son_prev_q;
  logic set_ev;
  logic res_ev;
  logic son_ev;
  logic [NUM_ALARMS-1:0] mask_set;
  logic [NUM_ALARMS-1:0] mask_res;
  logic [NUM_ALARMS-1:0] mask_son;
  logic [NUM_ALARMS-1:0] clr_ok;
  logic [NUM_ALARMS-1:0] alarm_q;
  logic [NUM_ALARMS-1:0] alarm_d;
  logic [NUM_WARNS-1:0] warn_q;
  logic [NUM_WARNS-1:0] warn_d;
  logic [5:0] cur_idx_q;
  logic [5:0] cur_idx_d;
  logic cur_vld_q;
  logic cur_vld_d;
  logic cur_keep;
  sacm_pkg::sacm_alarm_info_type cur_info;
  logic code_en;
  logic [15:0] ctrl_q;
  logic [`SACM_IRQ_W-1:0] irq_stat_q;
  logic [`SACM_IRQ_W-1:0] irq_mask_q;
  logic [`SACM_IRQ_W-1:0] irq_ev;
  logic [`SACM_IRQ_W-1:0] irq_w1c;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic wr_ctrl;
  logic wr_istat;
  logic wr_imask;
  logic [63:0] alarm_wide;

  // ----------------------------------------
  // bus front end
  // ----------------------------------------
  sacm_ahb u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  // ----------------------------------------
  // pin synchronisers and clear events
  // ----------------------------------------
  sacm_sync #(
    .WIDTH(3)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({set_button_pin, alarm_clear_input, servo_on_pin}),
    .sync_out(pins_sync)
  );

  // rising edges of button, clear input and servo-on
  assign set_s = pins_sync[2];
  assign res_s = pins_sync[1];
  assign son_s = pins_sync[0];
  assign set_ev = set_s & ~set_prev_q;
  assign res_ev = res_s & ~res_prev_q;
  assign son_ev = son_s & ~son_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      set_prev_q <= 1'b0;
      res_prev_q <= 1'b0;
      son_prev_q <= 1'b0;
    end else begin
      set_prev_q <= set_s;
      res_prev_q <= res_s;
      son_prev_q <= son_s;
    end
  end

  // ----------------------------------------
  // alarm latches
  // ----------------------------------------

  // per-alarm permitted clear sources
  for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_mask
    sacm_pkg::sacm_alarm_info_type info;
    assign info = alarm_info(6'(g));
    assign mask_set[g] = info.by_set;
    assign mask_res[g] = info.by_res;
    assign mask_son[g] = info.by_son;
  end

  // clear only with a permitted event and the cause gone; power-only alarms have no mask
  assign clr_ok = ~alarm_cause & (({NUM_ALARMS{set_ev}} & mask_set) |
                                  ({NUM_ALARMS{res_ev}} & mask_res) |
                                  ({NUM_ALARMS{son_ev}} & mask_son));
  assign alarm_d = alarm_cause | (alarm_q & ~clr_ok);

  // warnings follow their cause, battery low stays until reset
  always_comb begin
    warn_d = warning_cause;
    warn_d[`SACM_BATT_WARN_IDX] = warning_cause[`SACM_BATT_WARN_IDX] |
                                  warn_q[`SACM_BATT_WARN_IDX];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_q <= '0;
      warn_q <= '0;
    end else begin
      alarm_q <= alarm_d;
      warn_q <= warn_d;
    end
  end

  // ----------------------------------------
  // displayed alarm selection
  // ----------------------------------------

  // hold the first latched alarm until it clears, then take the lowest pending
  assign cur_keep = cur_vld_q & alarm_q[cur_idx_q];
  assign cur_idx_d = cur_keep ? cur_idx_q : first_alarm(alarm_q);
  assign cur_vld_d = cur_keep | (|alarm_q);
  assign cur_info = alarm_info(cur_idx_q);
  assign code_en = (ctrl_q[3:0] == `SACM_CODE_ON_DIGIT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_idx_q <= 6'd0;
      cur_vld_q <= 1'b0;
    end else begin
      cur_idx_q <= cur_idx_d;
      cur_vld_q <= cur_vld_d;
    end
  end

  // ----------------------------------------
  // discrete outputs and display
  // ----------------------------------------

  // code replaces normal functions only while an alarm is shown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coded_output_bit_a <= 1'b0;
      coded_output_bit_b <= 1'b0;
      coded_output_bit_c <= 1'b0;
      fault_flag_output <= 1'b0;
      caution_flag_output <= 1'b0;
      display_code <= 8'h00;
      display_is_alarm <= 1'b0;
    end else begin
      if (code_en && cur_vld_q) begin
        coded_output_bit_a <= cur_info.code[2];
        coded_output_bit_b <= cur_info.code[1];
        coded_output_bit_c <= cur_info.code[0];
      end else begin
        coded_output_bit_a <= normal_do_a;
        coded_output_bit_b <= normal_do_b;
        coded_output_bit_c <= normal_do_c;
      end
      fault_flag_output <= cur_vld_q;
      caution_flag_output <= |warn_q;
      display_is_alarm <= cur_vld_q;
      if (cur_vld_q) begin
        display_code <= cur_info.disp;
      end else if (|warn_q) begin
        display_code <= warn_disp(first_warn(warn_q));
      end else begin
        display_code <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // registers and interrupt
  // ----------------------------------------

  // write decode and events
  assign wr_ctrl = reg_wr & (reg_addr == `SACM_OFS_CTRL);
  assign wr_istat = reg_wr & (reg_addr == `SACM_OFS_IRQ_STAT);
  assign wr_imask = reg_wr & (reg_addr == `SACM_OFS_IRQ_MASK);
  assign irq_w1c = wr_istat ? reg_wdata[`SACM_IRQ_W-1:0] : '0;
  assign irq_ev[`SACM_IRQ_ALARM_SET] = |(alarm_d & ~alarm_q);
  assign irq_ev[`SACM_IRQ_WARN_SET] = |(warn_d & ~warn_q);
  assign irq_ev[`SACM_IRQ_ALARM_CLR] = |(alarm_q & ~alarm_d);
  assign irq = |(irq_stat_q & irq_mask_q);
  assign alarm_wide = 64'(alarm_q);

  // sticky status, set beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `SACM_CTRL_RESET;
      irq_stat_q <= `SACM_IRQ_RESET;
      irq_mask_q <= `SACM_IRQ_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata[15:0];
      end
      if (wr_imask) begin
        irq_mask_q <= reg_wdata[`SACM_IRQ_W-1:0];
      end
      irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_ev;
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `SACM_OFS_CTRL: reg_rdata = {16'h0000, ctrl_q};
        `SACM_OFS_STATUS: reg_rdata = {16'h0000, cur_info.disp, cur_idx_q[5:0],
                                       |warn_q, cur_vld_q};
        `SACM_OFS_ALARM_LO: reg_rdata = alarm_wide[31:0];
        `SACM_OFS_ALARM_HI: reg_rdata = alarm_wide[63:32];
        `SACM_OFS_WARN: reg_rdata = 32'(warn_q);
        `SACM_OFS_IRQ_STAT: reg_rdata = 32'(irq_stat_q);
        `SACM_OFS_IRQ_MASK: reg_rdata = 32'(irq_mask_q);
        default: reg_rdata = 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== rtl/sacm_cfg.svh
// constants for the servo alarm code manager
`ifndef SACM_CFG_SVH
`define SACM_CFG_SVH

// ----------------------------------------
// table sizes
// ----------------------------------------
`define SACM_NUM_ALARMS 37
`define SACM_NUM_WARNS 13
`define SACM_IDX_W 6
`define SACM_BATT_WARN_IDX 12

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SACM_OFS_CTRL 8'h00
`define SACM_OFS_STATUS 8'h04
`define SACM_OFS_ALARM_LO 8'h08
`define SACM_OFS_ALARM_HI 8'h0c
`define SACM_OFS_WARN 8'h10
`define SACM_OFS_IRQ_STAT 8'h14
`define SACM_OFS_IRQ_MASK 8'h18

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SACM_CTRL_RESET 16'h0000
`define SACM_CODE_ON_DIGIT 4'h1
`define SACM_IRQ_W 3
`define SACM_IRQ_ALARM_SET 0
`define SACM_IRQ_WARN_SET 1
`define SACM_IRQ_ALARM_CLR 2
`define SACM_IRQ_RESET 3'h0

`endif

// ===== rtl/sacm_pkg.sv
// types for the servo alarm code manager
package sacm_pkg;

  // bus slave phase
  typedef enum logic [0:0] {
    sacm_bus_idle,
    sacm_bus_access
  } sacm_bus_state_type;

  // per-alarm table entry
  typedef struct packed {
    logic [7:0] disp;
    logic [2:0] code;
    logic by_set;
    logic by_res;
    logic by_son;
  } sacm_alarm_info_type;

endpackage

// ===== rtl/sacm_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sacm_sync #(
  parameter int WIDTH = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage read only by second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ===== rtl/sacm_ahb.sv
// ahb-lite slave front end with one wait state
`timescale 1ns/10ps
module sacm_ahb (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);

  sacm_pkg::sacm_bus_state_type state_q;
  logic write_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic start;

  // address phase accepted, writes only at word size, other sizes read
  assign start = hsel & htrans[1] & hready & (state_q == sacm_pkg::sacm_bus_idle);
  assign hreadyout = (state_q == sacm_pkg::sacm_bus_idle);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign reg_addr = addr_q;
  assign reg_wdata = hwdata;
  assign reg_wr = (state_q == sacm_pkg::sacm_bus_access) & write_q;
  assign reg_rd = (state_q == sacm_pkg::sacm_bus_access) & ~write_q;

  // phase tracking and read capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= sacm_pkg::sacm_bus_idle;
      write_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        sacm_pkg::sacm_bus_idle: begin
          if (start) begin
            state_q <= sacm_pkg::sacm_bus_access;
            write_q <= hwrite & (hsize == 3'h2);
            addr_q <= {haddr[7:2], 2'b00};
          end
        end
        sacm_pkg::sacm_bus_access: begin
          state_q <= sacm_pkg::sacm_bus_idle;
          if (!write_q) begin
            hrdata_q <= reg_rdata;
          end
        end
        default: state_q <= sacm_pkg::sacm_bus_idle;
      endcase
    end
  end

endmodule

// ===== bench/sacm_chk.sv
// concurrent checks on the alarm manager ports
`timescale 1ns/10ps
module sacm_chk #(
  parameter int NUM_ALARMS = 37,
  parameter int NUM_WARNS = 13
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [NUM_ALARMS-1:0] alarm_cause,
  input wire logic [NUM_WARNS-1:0] warning_cause,
  input wire logic set_button_pin,
  input wire logic alarm_clear_input,
  input wire logic servo_on_pin,
  input wire logic normal_do_a,
  input wire logic normal_do_b,
  input wire logic normal_do_c,
  input wire logic coded_output_bit_a,
  input wire logic coded_output_bit_b,
  input wire logic coded_output_bit_c,
  input wire logic fault_flag_output,
  input wire logic caution_flag_output,
  input wire logic [7:0] display_code,
  input wire logic display_is_alarm
);
  // ----------------------------------------
  // bus and alarm relations
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_taken;
    hsel && htrans[1] && hready && hreadyout;
  endsequence
  sequence s_quiet;
    (!set_button_pin && !alarm_clear_input && !servo_on_pin) [*8];
  endsequence
  property p_wait;
    s_taken |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("data phase length wrong");
  property p_okay;
    s_taken |=> !hresp ##1 !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_fault;
    |alarm_cause |-> ##[2:3] fault_flag_output;
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag missing");
  property p_warn;
    |warning_cause |-> ##[1:2] caution_flag_output;
  endproperty
  a_warn: assert property (p_warn) else $error("caution flag missing");
  property p_hold;
    s_quiet ##0 fault_flag_output |=> fault_flag_output;
  endproperty
  a_hold: assert property (p_hold) else $error("alarm dropped unasked");
  property p_pass;
    $past(hresetn) && !fault_flag_output |->
      {coded_output_bit_a, coded_output_bit_b, coded_output_bit_c} ==
      $past({normal_do_a, normal_do_b, normal_do_c});
  endproperty
  a_pass: assert property (p_pass) else $error("normal levels lost");
  property p_disp;
    fault_flag_output |-> display_is_alarm && display_code != 8'h00;
  endproperty
  a_disp: assert property (p_disp) else $error("alarm not displayed");
  property p_idle;
    !fault_flag_output && !caution_flag_output |-> display_code == 8'h00 && !display_is_alarm;
  endproperty
  a_idle: assert property (p_idle) else $error("display not blank");
endmodule

// ===== bench/sacm_plc.sv
// controller input image of the discrete alarm lines
`timescale 1ns/10ps
module sacm_plc (
  input wire logic hclk,
  input wire logic [4:0] lines,
  output logic [4:0] image
);
  // scan the five lines once per clock
  always_ff @(posedge hclk) begin
    image <= lines;
  end
endmodule

// ===== bench/test_servo_alarm_code_manager.sv
// self-checking testbench of the servo alarm code manager
`timescale 1ns/10ps
`include "sacm_cfg.svh"
module test_servo_alarm_code_manager;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, r;
  logic [36:0] alarm_cause = 37'h0;
  logic [12:0] warning_cause = 13'h0, wm;
  logic set_button_pin = 1'b0, alarm_clear_input = 1'b0, servo_on_pin = 1'b0;
  logic normal_do_a = 1'b0, normal_do_b = 1'b0, normal_do_c = 1'b0;
  logic coded_output_bit_a, coded_output_bit_b, coded_output_bit_c, hreadyout, hresp;
  logic fault_flag_output, caution_flag_output, display_is_alarm, irq, en;
  logic [7:0] display_code;
  logic [4:0] image;
  int errors = 0, n_compared = 0, q[$];
  string cs = "2132455500660007776066666633333300000";
  sacm_top sacm_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .alarm_cause, .warning_cause,
    .set_button_pin, .alarm_clear_input, .servo_on_pin, .normal_do_a, .normal_do_b,
    .normal_do_c, .coded_output_bit_a, .coded_output_bit_b, .coded_output_bit_c,
    .fault_flag_output, .caution_flag_output, .display_code, .display_is_alarm, .irq);
  sacm_plc sacm_plc_inst (.hclk, .image, .lines({coded_output_bit_a, coded_output_bit_b,
    coded_output_bit_c, fault_flag_output, caution_flag_output}));
  // ----------------------------------------
  // model and helpers
  // ----------------------------------------
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  function automatic int cl(int i, int s);
    if (i == 33) return 1;
    if (s == 2) return 0;
    return int'(i inside {1, [3:9], 28, [34:36]});
  endfunction
  function automatic logic [4:0] expo();
    logic [2:0] k;
    k = {normal_do_a, normal_do_b, normal_do_c};
    if (q.size() > 0 && en) k = 3'(cs[q[0]] - "0");
    return {k, 1'(q.size() > 0), |wm};
  endfunction
  task automatic cmp(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge hclk);
  endtask
  // one single word transfer, waiting on hready at each phase
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk iff hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk iff hreadyout);
    r = hrdata;
  endtask
  task automatic rst(logic [31:0] c);
    @(posedge hclk);
    hresetn <= 1'b0;
    tick(4);
    hresetn <= 1'b1;
    q.delete();
    wm = 13'h0;
    en = c[3:0] == 4'h1;
    xf(1'b1, `SACM_OFS_CTRL, c);
  endtask
  task automatic al(int i);
    @(posedge hclk);
    {normal_do_a, normal_do_b, normal_do_c} <= 3'($urandom());
    alarm_cause[i] <= 1'b1;
    @(posedge hclk);
    alarm_cause <= 37'h0;
    tick(5);
    if (!(i inside {q})) q.push_back(i);
  endtask
  task automatic pin(int s);
    @(posedge hclk);
    set_button_pin <= s == 0;
    alarm_clear_input <= s == 1;
    servo_on_pin <= s == 2;
    tick(4);
    {set_button_pin, alarm_clear_input, servo_on_pin} <= 3'h0;
    tick(8);
    for (int j = q.size() - 1; j >= 0; j--) if (cl(q[j], s) != 0) q.delete(j);
  endtask
  task automatic ck(logic [4:0] m);
    tick(2);
    @(negedge hclk);
    cmp(32'(image & m), 32'(expo() & m));
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #500000;
    errors++;
    summarize();
  end
  initial begin
    void'($urandom(68975));
    rst(32'h0);
    xf(1'b0, `SACM_OFS_CTRL, 32'h0);
    cmp(r, 32'h0);
    xf(1'b0, 8'h40, 32'h0);
    cmp(r, 32'h0);
    al(24);
    ck(5'h1f);
    xf(1'b1, `SACM_OFS_CTRL, 32'h21);
    en = 1'b1;
    ck(5'h1f);
    xf(1'b0, `SACM_OFS_ALARM_LO, 32'h0);
    cmp(r, 32'h01000000);
    $display("code enable test done");
    for (int i = 0; i < 37; i++) begin
      rst(32'h1);
      ck(5'h1f);
      al(i);
      ck(5'h1f);
      for (int s = 0; s < 3; s++) begin
        pin(s);
        ck(5'h1f);
      end
    end
    $display("alarm table test done");
    rst(32'h1);
    al(8);
    al(0);
    ck(5'h1f);
    cmp(32'(display_code), 32'h09);
    pin(0);
    ck(5'h1f);
    cmp(32'(display_code), 32'h01);
    $display("priority test done");
    rst(32'h1);
    for (int w = 0; w < 13; w++) begin
      @(posedge hclk);
      warning_cause[w] <= 1'b1;
      wm[w] = 1'b1;
      tick(4);
      ck(5'h1f);
      cmp(32'(display_code), w < 11 ? 32'h12 + w : 32'h21 + w);
      @(posedge hclk);
      warning_cause <= 13'h0;
      wm[w] = w == 12;
      tick(4);
      ck(5'h1f);
    end
    rst(32'h1);
    ck(5'h1f);
    $display("warning test done");
    xf(1'b1, `SACM_OFS_IRQ_MASK, 32'h7);
    al(1);
    @(negedge hclk);
    cmp(32'(irq), 32'h1);
    xf(1'b1, `SACM_OFS_IRQ_MASK, 32'h0);
    @(negedge hclk);
    cmp(32'(irq), 32'h0);
    xf(1'b1, `SACM_OFS_IRQ_MASK, 32'h1);
    @(negedge hclk);
    cmp(32'(irq), 32'h1);
    xf(1'b1, `SACM_OFS_IRQ_STAT, 32'h7);
    @(negedge hclk);
    cmp(32'(irq), 32'h0);
    $display("interrupt test done");
    summarize();
  end
endmodule
bind sacm_top sacm_chk #(.NUM_ALARMS(NUM_ALARMS), .NUM_WARNS(NUM_WARNS)) sacm_chk_inst (
  .hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout, .hresp, .alarm_cause,
  .warning_cause, .set_button_pin, .alarm_clear_input, .servo_on_pin, .normal_do_a,
  .normal_do_b, .normal_do_c, .coded_output_bit_a, .coded_output_bit_b, .coded_output_bit_c,
  .fault_flag_output, .caution_flag_output, .display_code, .display_is_alarm);
